/* File: logic/cpe_pkg.sv */
package cpe_pkg;
   // node state as seen by this block
   typedef enum logic [1:0] {
      CPE_NMT_PREOP,
      CPE_NMT_OP,
      CPE_NMT_STOP
   } cpe_nmt_e;

   localparam int unsigned CPE_CLK_HZ       = 200_000_000;
   localparam int unsigned CPE_MS_PER_S     = 1000;
   localparam int unsigned CPE_MS_CYCLES    = CPE_CLK_HZ / CPE_MS_PER_S;
   localparam int unsigned CPE_CLEAR_DELAY_MS = 1000;
   localparam int unsigned CPE_FIFO_DEPTH   = 8;
   localparam int unsigned CPE_FRAME_W      = 11 + 4 + 64;

   // identifier bases, node id is added on top
   localparam logic [10:0] CPE_COB_EMCY     = 11'h080;
   localparam logic [10:0] CPE_COB_SDO_TX   = 11'h580;
   localparam logic [10:0] CPE_COB_SDO_RX   = 11'h600;
   localparam logic [10:0] CPE_COB_PDO [0:3] = '{11'h180, 11'h280, 11'h380, 11'h480};
   localparam logic [3:0]  CPE_DLC_FULL     = 4'h8;

   // expedited transfer command bytes
   localparam logic [7:0]  CPE_SDO_WR4      = 8'h23;
   localparam logic [7:0]  CPE_SDO_WR_ACK   = 8'h60;
   localparam logic [7:0]  CPE_SDO_RD       = 8'h40;
   localparam logic [7:0]  CPE_SDO_RD_ACK   = 8'h43;

   // object dictionary entries
   localparam logic [15:0] CPE_OBJ_CYCLIC   = 16'h2003;
   localparam logic [15:0] CPE_OBJ_FUSE     = 16'h2008;
   localparam logic [7:0]  CPE_SUB_ZERO     = 8'h00;
   localparam logic [31:0] CPE_CYCLIC_RESET = 32'h0000_0000;
   localparam logic [31:0] CPE_FUSE_RESET   = 32'h0000_0000;

   // emergency payload fields
   localparam logic [15:0] CPE_EEC_NONE     = 16'h0000;
   localparam logic [15:0] CPE_EEC_OTHER    = 16'hFF00;
   localparam logic [7:0]  CPE_ERB_NONE     = 8'h00;
   localparam logic [7:0]  CPE_ERB_OTHER    = 8'h81;
   localparam logic [7:0]  CPE_VNR_SUPPLY   = 8'h01;
endpackage : cpe_pkg

/* File: logic/cpe_frame_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module cpe_frame_fifo #(
   parameter int unsigned WIDTH = cpe_pkg::CPE_FRAME_W,
   parameter int unsigned DEPTH = cpe_pkg::CPE_FIFO_DEPTH
) (
   input  wire logic             i_clk,       // system clock
   input  wire logic             i_rst_n,     // synchronised reset
   input  wire logic             i_in_valid,  // write request
   input  wire logic [WIDTH-1:0] i_in_data,   // write word
   output logic                  o_in_ready,  // not full
   output logic                  o_out_valid, // not empty
   output logic [WIDTH-1:0]      o_out_data,  // head word
   input  wire logic             i_out_ready  // head taken
);
   import cpe_pkg::*;
   localparam int unsigned AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("fifo depth must be a power of two of at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             do_wr;
   logic             do_rd;

   always_comb begin
      o_in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
      o_out_valid = (wr_ptr != rd_ptr);
      o_out_data  = mem[rd_ptr[AW-1:0]];
      do_wr       = i_in_valid && o_in_ready;
      do_rd       = o_out_valid && i_out_ready;
      next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   always_ff @(posedge i_clk) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= i_in_data;
      end
   end

   fifo_count_a : assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (AW+1)'(wr_ptr - rd_ptr) <= DEPTH)
      else $error("fifo occupancy beyond depth");
endmodule : cpe_frame_fifo
`default_nettype wire

/* File: logic/cpe_tx_core.sv */
// Summary of operation
// - SDO 23h to 2003h sets interval, mask
// - send selected PDOs every interval milliseconds
// - zero interval stops cyclic sending
// - mask bits pick 180h/280h/380h/480h plus node
// - empty mask sends no cyclic PDO
// - cyclic PDOs only while Operational
// - reset discards the cyclic configuration
// - fixed payload layout per PDO kind
// - no emergency frames while stopped
// - one frame at onset, one at clear
// - emergency on 80h plus node, eight bytes
// - error code only 0000h or FF00h
// - bit 0 general, bit 7 vendor
// - error register byte 00h or 81h
// - first vendor byte is error number
// - supply loss FF00/81/01, return all zero
// - onset at once, clear after one second
// - object 2008h simulates blown supply fuse
// - SDO ignored while stopped
// - accepted SDO answered on 580h plus node
`timescale 1ns/1ps
`default_nettype none
module cpe_tx_core #(
   parameter int unsigned MS_CYCLES  = cpe_pkg::CPE_MS_CYCLES,
   parameter int unsigned FIFO_DEPTH = cpe_pkg::CPE_FIFO_DEPTH
) (
   input  wire logic             i_clk,                // system clock
   input  wire logic             i_reset_n,            // async reset, low
   input  wire logic [6:0]       i_node_id,            // node identifier
   input  wire cpe_pkg::cpe_nmt_e i_nmt_state,         // node state
   input  wire logic             i_nmt_reset,          // reset command pulse
   input  wire logic             i_rx_valid,           // received frame strobe
   input  wire logic [10:0]      i_rx_cob_id,          // received identifier
   input  wire logic [63:0]      i_rx_data,            // received bytes, D1 low
   input  wire logic [11:0]      i_digital_input,      // inputs 1..12
   input  wire logic [63:0]      i_analog_input,       // four 16-bit inputs
   input  wire logic [31:0]      i_sensor_resistance,  // two 16-bit resistances
   input  wire logic [31:0]      i_sensor_temperature, // two 16-bit temperatures
   input  wire logic [63:0]      i_counter,            // two 32-bit counters
   input  wire logic             i_supply_ok,          // input supply present
   output logic                  o_tx_valid,           // frame available
   output logic [10:0]           o_tx_cob_id,          // frame identifier
   output logic [3:0]            o_tx_dlc,             // frame length
   output logic [63:0]           o_tx_data,            // frame bytes, D1 low
   input  wire logic             i_tx_ready,           // controller takes frame
   output logic                  o_error_active        // supply error reported
);
   import cpe_pkg::*;
   localparam int unsigned MSW = $clog2(MS_CYCLES);
   localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);
   localparam logic [9:0] CLR_LAST = 10'(CPE_CLEAR_DELAY_MS - 1);

   generate
      if (MS_CYCLES < 2) begin : g_bad_ms
         $error("MS_CYCLES must be at least 2");
      end
   endgenerate

   function automatic logic [15:0] sdo_object(input logic [63:0] d);
      sdo_object = {d[23:16], d[15:8]};
   endfunction : sdo_object

   function automatic logic [63:0] sdo_answer(input logic [7:0] cmd, input logic [63:0] d,
                                              input logic [31:0] val);
      sdo_answer = {val, d[31:8], cmd};
   endfunction : sdo_answer

   ////////////////////////////////////////////////////////////////////////////
   logic             rst_meta;
   logic             rst_n;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [10:0]      node_ext;
   logic [10:0]      pdo_cob [0:3];

   assign node_ext = {4'h0, i_node_id};

   genvar gk;
   generate
      for (gk = 0; gk < 4; gk++) begin : g_cob
         assign pdo_cob[gk] = CPE_COB_PDO[gk] + node_ext;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   logic [MSW-1:0]   ms_cnt,     next_ms_cnt;
   logic             ms_tick,    next_ms_tick;
   logic [31:0]      cyclic_report_config, next_cyclic_report_config;
   logic [31:0]      fuse_break_simulation, next_fuse_break_simulation;
   logic [15:0]      ivl_cnt,    next_ivl_cnt;
   logic [3:0]       pdo_pend,   next_pdo_pend;
   logic             err_rep,    next_err_rep;
   logic [9:0]       clr_cnt,    next_clr_cnt;
   logic             emcy_pend,  next_emcy_pend;
   logic             emcy_clear, next_emcy_clear;
   logic             resp_pend,  next_resp_pend;
   logic [63:0]      resp_data,  next_resp_data;

   logic [15:0]      interval;
   logic [3:0]       sel_mask;
   logic             fault;
   logic             sdo_hit;
   logic             cfg_write;
   logic             push_valid;
   logic [78:0]      push_frame;
   logic             push_ready;
   logic             push_pdo;
   logic [78:0]      fifo_out;

   assign interval = cyclic_report_config[15:0];
   assign sel_mask = cyclic_report_config[19:16];
   assign fault    = !i_supply_ok || (fuse_break_simulation[7:0] != 8'h00);

   always_comb begin
      next_ms_cnt               = (ms_cnt == MS_LAST) ? '0 : ms_cnt + 1'b1;
      next_ms_tick              = (ms_cnt == MS_LAST);
      next_cyclic_report_config = cyclic_report_config;
      next_fuse_break_simulation = fuse_break_simulation;
      next_ivl_cnt              = ivl_cnt;
      next_pdo_pend             = pdo_pend;
      next_err_rep              = err_rep;
      next_clr_cnt              = clr_cnt;
      next_emcy_pend            = emcy_pend;
      next_emcy_clear           = emcy_clear;
      next_resp_pend            = resp_pend;
      next_resp_data            = resp_data;
      push_valid                = 1'b0;
      push_pdo                  = 1'b0;
      push_frame                = '0;
      cfg_write                 = 1'b0;

      // arbiter: emergency, then SDO answer, then lowest pending PDO
      if (emcy_pend && i_nmt_state != CPE_NMT_STOP) begin
         push_valid = 1'b1;
         push_frame = {CPE_COB_EMCY + node_ext, CPE_DLC_FULL, 32'h0,
                       emcy_clear ? 32'h0 : {CPE_VNR_SUPPLY, CPE_ERB_OTHER, CPE_EEC_OTHER}};
         if (push_ready) begin
            next_emcy_pend = 1'b0;
         end
      end else if (resp_pend) begin
         push_valid = 1'b1;
         push_frame = {CPE_COB_SDO_TX + node_ext, CPE_DLC_FULL, resp_data};
         if (push_ready) begin
            next_resp_pend = 1'b0;
         end
      end else if (pdo_pend != 4'h0 && i_nmt_state == CPE_NMT_OP) begin
         push_valid = 1'b1;
         push_pdo   = 1'b1;
         for (int k = 3; k >= 0; k--) begin
            if (pdo_pend[k]) begin
               push_frame[78:68] = pdo_cob[k];
            end
         end
         push_frame[67:64] = CPE_DLC_FULL;
         if (pdo_pend[0]) begin
            push_frame[63:0] = {48'h0, 4'h0, i_digital_input};
            if (push_ready) next_pdo_pend[0] = 1'b0;
         end else if (pdo_pend[1]) begin
            push_frame[63:0] = i_analog_input;
            if (push_ready) next_pdo_pend[1] = 1'b0;
         end else if (pdo_pend[2]) begin
            push_frame[63:0] = {i_sensor_temperature, i_sensor_resistance};
            if (push_ready) next_pdo_pend[2] = 1'b0;
         end else begin
            push_frame[63:0] = i_counter;
            if (push_ready) next_pdo_pend[3] = 1'b0;
         end
      end

      // expedited SDO access, ignored while stopped
      sdo_hit = i_rx_valid && (i_rx_cob_id == CPE_COB_SDO_RX + node_ext)
                && (i_nmt_state != CPE_NMT_STOP) && (i_rx_data[31:24] == CPE_SUB_ZERO);
      if (sdo_hit && sdo_object(i_rx_data) == CPE_OBJ_CYCLIC) begin
         if (i_rx_data[7:0] == CPE_SDO_WR4) begin
            next_cyclic_report_config = {8'h00, i_rx_data[55:32]};
            next_ivl_cnt   = '0;
            next_pdo_pend  = next_pdo_pend & i_rx_data[51:48];
            cfg_write      = 1'b1;
            next_resp_pend = 1'b1;
            next_resp_data = sdo_answer(CPE_SDO_WR_ACK, i_rx_data, 32'h0);
         end else if (i_rx_data[7:0] == CPE_SDO_RD) begin
            next_resp_pend = 1'b1;
            next_resp_data = sdo_answer(CPE_SDO_RD_ACK, i_rx_data, cyclic_report_config);
         end
      end else if (sdo_hit && sdo_object(i_rx_data) == CPE_OBJ_FUSE) begin
         if (i_rx_data[7:0] == CPE_SDO_WR4) begin
            next_fuse_break_simulation = i_rx_data[63:32];
            next_resp_pend = 1'b1;
            next_resp_data = sdo_answer(CPE_SDO_WR_ACK, i_rx_data, 32'h0);
         end else if (i_rx_data[7:0] == CPE_SDO_RD) begin
            next_resp_pend = 1'b1;
            next_resp_data = sdo_answer(CPE_SDO_RD_ACK, i_rx_data, fuse_break_simulation);
         end
      end

      // interval timer runs only in Operational with a live configuration
      if (i_nmt_state != CPE_NMT_OP) begin
         next_pdo_pend = 4'h0;
         next_ivl_cnt  = '0;
      end else if (!cfg_write && ms_tick && interval != 16'h0 && sel_mask != 4'h0) begin
         if (ivl_cnt >= interval - 16'h1) begin
            next_ivl_cnt  = '0;
            next_pdo_pend = next_pdo_pend | sel_mask;
         end else begin
            next_ivl_cnt = ivl_cnt + 16'h1;
         end
      end

      // supply monitor
      if (fault) begin
         next_clr_cnt = '0;
         if (emcy_pend && emcy_clear && !push_ready) begin
            next_emcy_pend = 1'b0;
            next_err_rep   = 1'b1;
         end else if (!err_rep) begin
            next_err_rep    = 1'b1;
            next_emcy_pend  = 1'b1;
            next_emcy_clear = 1'b0;
         end
      end else if (err_rep && ms_tick) begin
         if (clr_cnt == CLR_LAST) begin
            next_clr_cnt    = '0;
            next_err_rep    = 1'b0;
            next_emcy_pend  = 1'b1;
            next_emcy_clear = 1'b1;
         end else begin
            next_clr_cnt = clr_cnt + 10'h1;
         end
      end
      if (i_nmt_state == CPE_NMT_STOP) begin
         next_emcy_pend = 1'b0;
      end

      if (i_nmt_reset) begin
         next_cyclic_report_config  = CPE_CYCLIC_RESET;
         next_fuse_break_simulation = CPE_FUSE_RESET;
         next_ivl_cnt               = '0;
         next_pdo_pend              = 4'h0;
         next_resp_pend             = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         ms_cnt                <= '0;
         ms_tick               <= 1'b0;
         cyclic_report_config  <= CPE_CYCLIC_RESET;
         fuse_break_simulation <= CPE_FUSE_RESET;
         ivl_cnt               <= '0;
         pdo_pend              <= 4'h0;
         err_rep               <= 1'b0;
         clr_cnt               <= '0;
         emcy_pend             <= 1'b0;
         emcy_clear            <= 1'b0;
         resp_pend             <= 1'b0;
         resp_data             <= '0;
      end else begin
         ms_cnt                <= next_ms_cnt;
         ms_tick               <= next_ms_tick;
         cyclic_report_config  <= next_cyclic_report_config;
         fuse_break_simulation <= next_fuse_break_simulation;
         ivl_cnt               <= next_ivl_cnt;
         pdo_pend              <= next_pdo_pend;
         err_rep               <= next_err_rep;
         clr_cnt               <= next_clr_cnt;
         emcy_pend             <= next_emcy_pend;
         emcy_clear            <= next_emcy_clear;
         resp_pend             <= next_resp_pend;
         resp_data             <= next_resp_data;
      end
   end

   assign o_error_active = err_rep;

   ////////////////////////////////////////////////////////////////////////////
   cpe_frame_fifo #(
      .WIDTH (CPE_FRAME_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_rst_n     (rst_n),
      .i_in_valid  (push_valid),
      .i_in_data   (push_frame),
      .o_in_ready  (push_ready),
      .o_out_valid (o_tx_valid),
      .o_out_data  (fifo_out),
      .i_out_ready (i_tx_ready)
   );

   assign o_tx_cob_id = fifo_out[78:68];
   assign o_tx_dlc    = fifo_out[67:64];
   assign o_tx_data   = fifo_out[63:0];

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   sequence s_clear_due;
      !fault && err_rep && ms_tick && clr_cnt == CLR_LAST && i_nmt_state != CPE_NMT_STOP;
   endsequence
   sequence s_clear_queued;
      emcy_pend && emcy_clear && !err_rep;
   endsequence

   clear_delay_a : assert property (s_clear_due |=> s_clear_queued)
      else $error("clear frame not queued after delay");
   clear_early_a : assert property ($fell(err_rep) |-> $past(clr_cnt) == CLR_LAST)
      else $error("error cleared before one second");
   onset_now_a : assert property (fault && !err_rep && i_nmt_state != CPE_NMT_STOP
                                  && !(emcy_pend && emcy_clear && !push_ready)
                                  && !i_nmt_reset |=> emcy_pend && !emcy_clear)
      else $error("onset not queued at once");
   stop_emcy_a : assert property (push_valid && push_frame[78:68] == CPE_COB_EMCY + node_ext
                                  |-> i_nmt_state != CPE_NMT_STOP)
      else $error("emergency pushed while stopped");
   emcy_code_a : assert property (push_valid && push_frame[78:68] == CPE_COB_EMCY + node_ext
                                  |-> push_frame[15:0] == CPE_EEC_NONE && push_frame[23:16]
                                  == CPE_ERB_NONE || push_frame[15:0] == CPE_EEC_OTHER
                                  && push_frame[23:16] == CPE_ERB_OTHER)
      else $error("bad emergency code pair");
   emcy_first_a : assert property (emcy_pend |-> !push_pdo)
      else $error("pdo pushed ahead of emergency");
   pdo_op_only_a : assert property (push_pdo |-> i_nmt_state == CPE_NMT_OP && sel_mask != 4'h0)
      else $error("pdo pushed outside operational");
   zero_ivl_a : assert property (interval == 16'h0 && pdo_pend == 4'h0 |=> pdo_pend == 4'h0)
      else $error("pdo due with zero interval");
   sdo_ack_a : assert property (sdo_hit && (i_rx_data[7:0] == CPE_SDO_WR4) && !i_nmt_reset
                                && sdo_object(i_rx_data) == CPE_OBJ_CYCLIC
                                |=> resp_pend && resp_data[7:0] == CPE_SDO_WR_ACK
                                && interval == $past(i_rx_data[47:32]))
      else $error("configuration write not acknowledged");
   stop_sdo_a : assert property (i_nmt_state == CPE_NMT_STOP && !resp_pend |=> !resp_pend)
      else $error("sdo answered while stopped");
   reset_cfg_a : assert property (i_nmt_reset |=> cyclic_report_config == CPE_CYCLIC_RESET)
      else $error("configuration kept over reset");
endmodule : cpe_tx_core
`default_nettype wire

/* File: testbench/cpe_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpe_master_model (
   input  wire logic        i_clk,       // clock
   input  wire logic        i_stall,     // stall intake
   output logic             o_rx_valid,  // request strobe
   output logic [10:0]      o_rx_cob_id, // request id
   output logic [63:0]      o_rx_data,   // request bytes
   input  wire logic        i_tx_valid,  // frame offered
   input  wire logic [78:0] i_tx_frame,  // id, length, bytes
   output logic             o_tx_ready   // frame taken
);
   logic [78:0] rxq [$];
   initial begin
      o_rx_valid = 1'b0;
      o_rx_cob_id = 11'h000;
      o_rx_data = 64'h0;
   end
   // released lines show the inverse of the last value
   task automatic sdo(input logic [10:0] cob, input logic [63:0] d);
      @(posedge i_clk);
      #1;
      o_rx_cob_id = cob;
      o_rx_data = d;
      o_rx_valid = 1'b1;
      @(posedge i_clk);
      #1;
      o_rx_valid = 1'b0;
      o_rx_cob_id = ~cob;
      o_rx_data = ~d;
   endtask : sdo
   assign o_tx_ready = ~i_stall;
   always @(posedge i_clk) begin
      if (i_tx_valid && o_tx_ready) begin
         rxq.push_back(i_tx_frame);
      end
   end
endmodule : cpe_master_model
`default_nettype wire

/* File: testbench/cyclic_pdo_and_emergency_tx_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cyclic_pdo_and_emergency_tx_tb;
   import cpe_pkg::*;
   localparam int unsigned MSC = 20;
   localparam logic [6:0]  NODE = 7'h05;
   localparam logic [63:0] AIN = 64'h4444_3333_2222_1111;
   localparam logic [63:0] CNT = 64'h8765_4321_1234_5678;
   localparam logic [63:0] ONSET = {32'h0, CPE_VNR_SUPPLY, CPE_ERB_OTHER, CPE_EEC_OTHER};
   logic clk, rst_n, nmt_rst, sup_ok, stall, rx_valid, tx_valid, tx_ready, err;
   logic [10:0] rx_cob, tx_cob;
   logic [3:0]  tx_dlc;
   logic [11:0] din;
   logic [31:0] res, tmp;
   logic [63:0] rx_data, tx_data;
   cpe_nmt_e    state;
   int          miscompares, check_count;
   ////////////////////////////////////////////////////////////
   cpe_tx_core #(.MS_CYCLES(MSC), .FIFO_DEPTH(CPE_FIFO_DEPTH)) DUT (
      .i_clk(clk), .i_reset_n(rst_n), .i_node_id(NODE), .i_nmt_state(state),
      .i_nmt_reset(nmt_rst), .i_rx_valid(rx_valid), .i_rx_cob_id(rx_cob),
      .i_rx_data(rx_data), .i_digital_input(din), .i_analog_input(AIN),
      .i_sensor_resistance(res), .i_sensor_temperature(tmp), .i_counter(CNT),
      .i_supply_ok(sup_ok), .o_tx_valid(tx_valid), .o_tx_cob_id(tx_cob),
      .o_tx_dlc(tx_dlc), .o_tx_data(tx_data), .i_tx_ready(tx_ready),
      .o_error_active(err));
   cpe_master_model M (
      .i_clk(clk), .i_stall(stall), .o_rx_valid(rx_valid), .o_rx_cob_id(rx_cob),
      .o_rx_data(rx_data), .i_tx_valid(tx_valid),
      .i_tx_frame({tx_cob, tx_dlc, tx_data}), .o_tx_ready(tx_ready));
   function automatic logic [78:0] fr(input logic [10:0] b, input logic [63:0] d);
      return {b + {4'h0, NODE}, CPE_DLC_FULL, d};
   endfunction : fr
   function automatic logic [78:0] ans(input logic [7:0] c, input logic [15:0] o,
                                       input logic [31:0] v);
      return fr(CPE_COB_SDO_TX, {v, CPE_SUB_ZERO, o, c});
   endfunction : ans
   function automatic logic [63:0] pl(input int i);
      case (i)
         0: return {52'h0, din};
         1: return AIN;
         2: return {tmp, res};
         default: return CNT;
      endcase
   endfunction : pl
   task automatic sdo_req(input logic [7:0] c, input logic [15:0] o, input logic [31:0] v);
      M.sdo(CPE_COB_SDO_RX + {4'h0, NODE}, {v, CPE_SUB_ZERO, o, c});
   endtask : sdo_req
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic ms(input int n);
      cyc(n * MSC);
   endtask : ms
   task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val
   task automatic chk_fr(input string what, input logic [78:0] exp);
      logic [78:0] got;
      got = 'x;
      if (M.rxq.size() > 0) got = M.rxq.pop_front();
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_fr
   task automatic conclude();
      if (miscompares == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude
   task automatic t_config();
      sdo_req(CPE_SDO_WR4, CPE_OBJ_CYCLIC, 32'h000F_0002);
      ms(1);
      chk_fr("cfg ack", ans(CPE_SDO_WR_ACK, CPE_OBJ_CYCLIC, 32'h0));
      ms(3);
      chk_val("preop pdos", 0, M.rxq.size());
   endtask : t_config
   task automatic t_cyclic();
      stall = 1'b1;
      state = CPE_NMT_OP;
      cyc(90);
      state = CPE_NMT_PREOP;
      stall = 1'b0;
      cyc(20);
      for (int b = 0; b < 2; b++)
         for (int i = 0; i < 4; i++)
            chk_fr("pdo", fr(CPE_COB_PDO[i], pl(i)));
      chk_val("pdo count", 0, M.rxq.size());
   endtask : t_cyclic
   task automatic t_off();
      state = CPE_NMT_OP;
      sdo_req(CPE_SDO_WR4, CPE_OBJ_CYCLIC, 32'h000F_0000);
      ms(3);
      chk_fr("off ack", ans(CPE_SDO_WR_ACK, CPE_OBJ_CYCLIC, 32'h0));
      chk_val("zero interval", 0, M.rxq.size());
      sdo_req(CPE_SDO_WR4, CPE_OBJ_CYCLIC, 32'h0000_0001);
      ms(3);
      chk_fr("mask ack", ans(CPE_SDO_WR_ACK, CPE_OBJ_CYCLIC, 32'h0));
      chk_val("empty mask", 0, M.rxq.size());
      state = CPE_NMT_PREOP;
   endtask : t_off
   task automatic t_restart();
      state = CPE_NMT_OP;
      sdo_req(CPE_SDO_WR4, CPE_OBJ_CYCLIC, 32'h0001_0003);
      ms(1);
      sdo_req(CPE_SDO_WR4, CPE_OBJ_CYCLIC, 32'h0001_0003);
      ms(2);
      for (int i = 0; i < 2; i++)
         chk_fr("restart ack", ans(CPE_SDO_WR_ACK, CPE_OBJ_CYCLIC, 32'h0));
      chk_val("restart early", 0, M.rxq.size());
      ms(2);
      chk_fr("restart pdo", fr(CPE_COB_PDO[0], pl(0)));
      state = CPE_NMT_PREOP;
   endtask : t_restart
   task automatic t_reset();
      sdo_req(CPE_SDO_WR4, CPE_OBJ_CYCLIC, 32'h0001_0001);
      ms(1);
      chk_fr("pre ack", ans(CPE_SDO_WR_ACK, CPE_OBJ_CYCLIC, 32'h0));
      nmt_rst = 1'b1;
      cyc(1);
      nmt_rst = 1'b0;
      sdo_req(CPE_SDO_RD, CPE_OBJ_CYCLIC, 32'h0);
      ms(1);
      chk_fr("cfg reset", ans(CPE_SDO_RD_ACK, CPE_OBJ_CYCLIC, CPE_CYCLIC_RESET));
      state = CPE_NMT_OP;
      ms(3);
      chk_val("reset pdos", 0, M.rxq.size());
      state = CPE_NMT_PREOP;
   endtask : t_reset
   task automatic t_stop();
      state = CPE_NMT_STOP;
      sdo_req(CPE_SDO_WR4, CPE_OBJ_CYCLIC, 32'h0001_0001);
      sup_ok = 1'b0;
      ms(2);
      chk_val("stop frames", 0, M.rxq.size());
      sup_ok = 1'b1;
      ms(1010);
      state = CPE_NMT_PREOP;
      sdo_req(CPE_SDO_RD, CPE_OBJ_CYCLIC, 32'h0);
      ms(1);
      chk_fr("stop cfg", ans(CPE_SDO_RD_ACK, CPE_OBJ_CYCLIC, CPE_CYCLIC_RESET));
      chk_val("stop emcy", 0, M.rxq.size());
   endtask : t_stop
   task automatic t_emcy();
      sup_ok = 1'b0;
      cyc(6);
      chk_fr("onset", fr(CPE_COB_EMCY, ONSET));
      chk_val("err set", 1, {31'h0, err});
      sup_ok = 1'b1;
      ms(500);
      sup_ok = 1'b0;
      cyc(2);
      chk_val("no reonset", 0, M.rxq.size());
      sup_ok = 1'b1;
      ms(990);
      chk_val("early clear", 0, M.rxq.size());
      ms(20);
      chk_fr("clear", fr(CPE_COB_EMCY, 64'h0));
      chk_val("err clr", 0, {31'h0, err});
   endtask : t_emcy
   task automatic t_fuse();
      sdo_req(CPE_SDO_WR4, CPE_OBJ_FUSE, 32'h0000_0001);
      cyc(8);
      chk_fr("fuse ack", ans(CPE_SDO_WR_ACK, CPE_OBJ_FUSE, 32'h0));
      chk_fr("fuse onset", fr(CPE_COB_EMCY, ONSET));
      sdo_req(CPE_SDO_RD, CPE_OBJ_FUSE, 32'h0);
      cyc(8);
      chk_fr("fuse read", ans(CPE_SDO_RD_ACK, CPE_OBJ_FUSE, 32'h0000_0001));
   endtask : t_fuse
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      conclude();
   end
   initial begin
      rst_n = 1'b0;
      nmt_rst = 1'b0;
      sup_ok = 1'b1;
      stall = 1'b0;
      state = CPE_NMT_PREOP;
      din = 12'hA5C;
      res = 32'h0B0B_0A0A;
      tmp = 32'h0D0D_0C0C;
      miscompares = 0;
      check_count = 0;
      cyc(12);
      rst_n = 1'b1;
      cyc(5);
      t_config();
      t_cyclic();
      t_off();
      t_restart();
      t_reset();
      t_stop();
      t_emcy();
      t_fuse();
      conclude();
   end
endmodule : cyclic_pdo_and_emergency_tx_tb
`default_nettype wire
